//--- bmr_host.sv
module bmr_host
(
   // Clock
   input  wire logic        CORE_CLK,
   // Request side
   output logic             PSEL,
   output logic             PENABLE,
   output logic             PWRITE,
   output logic [7:0]       PADDR,
   output logic [31:0]      PWDATA,
   output logic [3:0]       PSTRB,
   // Answer side
   input  wire logic [31:0] PRDATA,
   input  wire logic        PREADY,
   input  wire logic        PSLVERR
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle from time zero
   initial
   begin
      {PSEL, PENABLE, PWRITE, PSTRB} = '0;
      {PADDR, PWDATA} = '0;
   end

   // ************************************************************
   // One transfer; holds the request until ready is seen high
   // ************************************************************
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
      @(posedge CORE_CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      PSTRB   <= s;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      // No cycle count assumed; a dead slave is left to the watchdog
      do
         @(posedge CORE_CLK);
      while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      PWDATA  <= ~d;
   endtask : xfer

   // Whole group in one go, so no half-written threshold is left
   task automatic grp_wr(input logic [7:0] a, input logic [31:0] lo, hi);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, lo, 4'hF, r, e);
      xfer(1'b1, a + 8'h04, hi, 4'hF, r, e);
   endtask : grp_wr
endmodule : bmr_host

//--- bmr_pkg.sv
// Behaviour
// - A byte 0: GPIO1-5 pull-downs 7:3, keep-on 2, timer enable 1, option 0.
// - Undervoltage threshold: low byte in A byte 1, upper nibble in A byte 2.
// - Overvoltage threshold: low nibble in A byte 2 7:4, high byte A byte 3.
// - Cell 1-12 discharge enables in A bytes 4-5, timeout in byte 5 7:4.
// - B byte 0: GPIO6-9 pull-downs, cell 13-15 discharge 4-6, 7 reserved.
// - B byte 1: mute, forced failure, path, timer monitor, extra discharge.
// - Result groups are read-only; each result is 16 bits, low byte first.
// - Cell groups A to E hold cells 1-3, 4-6, 7-9, 10-12, 13-15 ascending.
// - Overlap: cell 6 by second converter in cell group C bytes 0-1.
// - Overlap: cell 6 by first converter in cell group C bytes 2-3.
// - Overlap: cell 11 by third converter in cell group E bytes 0-1.
// - Overlap: cell 11 by second converter in cell group E bytes 2-3.
// - Aux group A holds GPIO 1-3, B bytes 0-3 GPIO 4-5, C GPIO 6-8.
// - Second reference result in aux group B bytes 4-5, low byte first.
// - Option 0 picks the 27k/7k/26/422 Hz set, 1 the 14k/3k/2k/1k set.
package bmr_pkg;

   // ************************************************************
   // Register map, one 32-bit word each
   // ************************************************************
   localparam logic [7:0] OFF_CFGA_LO  = 8'h00;
   localparam logic [7:0] OFF_CFGA_HI  = 8'h04;
   localparam logic [7:0] OFF_CFGB_LO  = 8'h08;
   localparam logic [7:0] OFF_CFGB_HI  = 8'h0C;
   localparam logic [7:0] OFF_RES_BASE = 8'h10;
   localparam logic [7:0] OFF_RES_END  = 8'h50;

   // ************************************************************
   // Field positions inside a six-byte group
   // ************************************************************
   localparam int A_OPT     = 0;
   localparam int A_TMR_EN  = 1;
   localparam int A_REF_ON  = 2;
   localparam int A_GPIO_PD = 3;
   localparam int A_UV      = 8;
   localparam int A_OV      = 20;
   localparam int A_DISCH   = 32;
   localparam int A_DIS_TMO = 44;
   localparam int B_GPIO_PD = 0;
   localparam int B_DISCH   = 4;
   localparam int B_XDISCH  = 10;
   localparam int B_TMR_MON = 11;
   localparam int B_PATH    = 12;
   localparam int B_FFAIL   = 14;
   localparam int B_MUTE    = 15;

   // ************************************************************
   // Result slots: three per group, cells then aux
   // ************************************************************
   localparam int NUM_SLOTS       = 24;
   localparam int SLOT_C6_ADC2    = 6;
   localparam int SLOT_C6_ADC1    = 7;
   localparam int SLOT_C11_ADC3   = 12;
   localparam int SLOT_C11_ADC2   = 13;
   localparam int SLOT_REF        = 20;
   localparam logic [15:0] RES_RST = 16'h0000;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic [8:0]  gpio_pulldown;
      logic        reference_keep_on;
      logic        discharge_timer_enable;
      logic        converter_rate_option;
      logic [11:0] undervoltage_threshold;
      logic [11:0] overvoltage_threshold;
      logic [14:0] cell_discharge_enable;
      logic [3:0]  discharge_timeout;
      logic        discharge_mute;
      logic        forced_redundancy_failure;
      logic [1:0]  redundancy_path_select;
      logic        timer_monitor_enable;
      logic        extra_discharge_control;
   } bmr_cfg_t;

   localparam bmr_cfg_t CFG_RST = '0;

   typedef struct packed {
      logic        valid;
      logic [4:0]  chan;
      logic [15:0] data;
   } bmr_result_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] c6_adc2;
      logic [15:0] c6_adc1;
      logic [15:0] c11_adc3;
      logic [15:0] c11_adc2;
   } bmr_overlap_t;

   // Code is {rate option, conversion_rate_select}
   typedef enum logic [2:0] {
      RATE_422HZ = 3'b000,
      RATE_27KHZ = 3'b001,
      RATE_7KHZ  = 3'b010,
      RATE_26HZ  = 3'b011,
      RATE_1KHZ  = 3'b100,
      RATE_14KHZ = 3'b101,
      RATE_3KHZ  = 3'b110,
      RATE_2KHZ  = 3'b111
   } bmr_rate_t;

endpackage : bmr_pkg

//--- bmr_regs.sv
module bmr_regs
(
   // Clock and reset
   input  wire logic                 CORE_CLK,
   input  wire logic                 RSTN,
   // APB slave
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [7:0]           PADDR,
   input  wire logic [31:0]          PWDATA,
   input  wire logic [3:0]           PSTRB,
   output logic      [31:0]          PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   // Measurement results
   input  wire bmr_pkg::bmr_result_t  RESULT,
   input  wire bmr_pkg::bmr_overlap_t OVERLAP,
   input  wire logic [1:0]           CONV_MODE,
   // Configuration to the analog side
   output bmr_pkg::bmr_cfg_t         CFG,
   output bmr_pkg::bmr_rate_t        RATE
);

   localparam int N = bmr_pkg::NUM_SLOTS;

   bmr_pkg::bmr_cfg_t  cfg_reg;
   bmr_pkg::bmr_rate_t rate_reg;
   logic [31:0]        prdata_reg;
   logic               pready_reg;
   logic               pslverr_reg;
   logic [N-1:0]       res_we;
   logic [N-1:0][15:0] res_wd;
   logic [N-1:0][15:0] res_q;
   logic [47:0]        cfga_b;
   logic [15:0]        cfgb_b;
   logic [31:0]        wmask;
   logic [47:0]        cfga_next;
   logic [15:0]        cfgb_next;
   logic [3:0]         res_grp;
   logic [4:0]         slot0;
   logic               is_res;
   logic [31:0]        rd_data;
   logic               rd_err;
   logic               acc_go;
   logic               wr_go;

   // ************************************************************
   // Byte images of the configuration groups
   // ************************************************************
   function automatic logic [47:0] pack_a(bmr_pkg::bmr_cfg_t c);
      logic [47:0] b;
      b = '0;
      b[bmr_pkg::A_GPIO_PD +: 5] = c.gpio_pulldown[4:0];
      b[bmr_pkg::A_REF_ON]       = c.reference_keep_on;
      b[bmr_pkg::A_TMR_EN]       = c.discharge_timer_enable;
      b[bmr_pkg::A_OPT]          = c.converter_rate_option;
      b[bmr_pkg::A_UV +: 12]     = c.undervoltage_threshold;
      b[bmr_pkg::A_OV +: 12]     = c.overvoltage_threshold;
      b[bmr_pkg::A_DISCH +: 12]  = c.cell_discharge_enable[11:0];
      b[bmr_pkg::A_DIS_TMO +: 4] = c.discharge_timeout;
      return b;
   endfunction : pack_a

   // Bit 7 and bits 9:8 stay zero, so reserved bits read zero
   function automatic logic [15:0] pack_b(bmr_pkg::bmr_cfg_t c);
      logic [15:0] b;
      b = '0;
      b[bmr_pkg::B_GPIO_PD +: 4] = c.gpio_pulldown[8:5];
      b[bmr_pkg::B_DISCH +: 3] = c.cell_discharge_enable[14:12];
      b[bmr_pkg::B_MUTE]      = c.discharge_mute;
      b[bmr_pkg::B_FFAIL]     = c.forced_redundancy_failure;
      b[bmr_pkg::B_PATH +: 2] = c.redundancy_path_select;
      b[bmr_pkg::B_TMR_MON]   = c.timer_monitor_enable;
      b[bmr_pkg::B_XDISCH]    = c.extra_discharge_control;
      return b;
   endfunction : pack_b

   function automatic bmr_pkg::bmr_cfg_t unpack_a(bmr_pkg::bmr_cfg_t c,
                                                  logic [47:0] b);
      bmr_pkg::bmr_cfg_t r;
      r = c;
      r.gpio_pulldown[4:0]     = b[bmr_pkg::A_GPIO_PD +: 5];
      r.reference_keep_on      = b[bmr_pkg::A_REF_ON];
      r.discharge_timer_enable = b[bmr_pkg::A_TMR_EN];
      r.converter_rate_option  = b[bmr_pkg::A_OPT];
      r.undervoltage_threshold = b[bmr_pkg::A_UV +: 12];
      r.overvoltage_threshold  = b[bmr_pkg::A_OV +: 12];
      r.cell_discharge_enable[11:0] = b[bmr_pkg::A_DISCH +: 12];
      r.discharge_timeout      = b[bmr_pkg::A_DIS_TMO +: 4];
      return r;
   endfunction : unpack_a

   function automatic bmr_pkg::bmr_cfg_t unpack_b(bmr_pkg::bmr_cfg_t c,
                                                  logic [15:0] b);
      bmr_pkg::bmr_cfg_t r;
      r = c;
      r.gpio_pulldown[8:5]     = b[bmr_pkg::B_GPIO_PD +: 4];
      r.cell_discharge_enable[14:12] = b[bmr_pkg::B_DISCH +: 3];
      r.discharge_mute         = b[bmr_pkg::B_MUTE];
      r.forced_redundancy_failure = b[bmr_pkg::B_FFAIL];
      r.redundancy_path_select = b[bmr_pkg::B_PATH +: 2];
      r.timer_monitor_enable   = b[bmr_pkg::B_TMR_MON];
      r.extra_discharge_control = b[bmr_pkg::B_XDISCH];
      return r;
   endfunction : unpack_b

   // ************************************************************
   // APB decode
   // ************************************************************
   assign acc_go  = PSEL && PENABLE && pready_reg;
   assign wr_go   = acc_go && PWRITE;
   assign cfga_b  = pack_a(cfg_reg);
   assign cfgb_b  = pack_b(cfg_reg);
   assign is_res  = (PADDR[1:0] == 2'b00) &&
                    (PADDR >= bmr_pkg::OFF_RES_BASE) &&
                    (PADDR < bmr_pkg::OFF_RES_END);
   assign res_grp = PADDR[6:3] - 4'h2;
   // Three slots per group, so group g starts at slot 3g
   assign slot0   = 5'({1'b0, res_grp}) * 5'd3;

   // Byte strobes widened to a bit mask
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         wmask[8*i +: 8] = {8{PSTRB[i]}};
   end

   // Merge of write data into the group images
   always_comb
   begin
      cfga_next = cfga_b;
      cfgb_next = cfgb_b;
      if (PADDR == bmr_pkg::OFF_CFGA_LO)
         cfga_next[31:0] = (cfga_b[31:0] & ~wmask) | (PWDATA & wmask);
      else if (PADDR == bmr_pkg::OFF_CFGA_HI)
         cfga_next[47:32] = (cfga_b[47:32] & ~wmask[15:0]) |
                            (PWDATA[15:0] & wmask[15:0]);
      // Only bytes 0 and 1 of group B carry anything
      cfgb_next = (cfgb_b & ~wmask[15:0]) |
                  (PWDATA[15:0] & wmask[15:0]);
   end

   // Read mux; unmapped or misaligned addresses answer with an error
   always_comb
   begin
      rd_data = '0;
      rd_err  = 1'b0;
      if (PADDR == bmr_pkg::OFF_CFGA_LO)
         rd_data = cfga_b[31:0];
      else if (PADDR == bmr_pkg::OFF_CFGA_HI)
         rd_data = {16'h0000, cfga_b[47:32]};
      else if (PADDR == bmr_pkg::OFF_CFGB_LO)
         rd_data = {16'h0000, cfgb_b};
      else if (PADDR == bmr_pkg::OFF_CFGB_HI)
         rd_data = '0;
      else if (is_res && PADDR[2])
         rd_data = {16'h0000, res_q[5'(slot0 + 5'd2)]};
      else if (is_res)
         rd_data = {res_q[5'(slot0 + 5'd1)], res_q[slot0]};
      else
         rd_err = 1'b1;
   end

   // ************************************************************
   // APB handshake: one wait state, then a one-cycle ready
   // ************************************************************
   // The wait state lets read data come from a flop
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
         pready_reg <= 1'b0;
      else
         pready_reg <= PSEL && PENABLE && !pready_reg;
   end

   // Read data and error captured in the wait state
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
      else if (PSEL && PENABLE && !pready_reg)
      begin
         prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_data;
         pslverr_reg <= rd_err;
      end
      else
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Configuration storage
   // ************************************************************
   // Writes take effect only at the edge that completes the access
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
         cfg_reg <= bmr_pkg::CFG_RST;
      else if (wr_go && (PADDR == bmr_pkg::OFF_CFGA_LO ||
                         PADDR == bmr_pkg::OFF_CFGA_HI))
         cfg_reg <= unpack_a(cfg_reg, cfga_next);
      else if (wr_go && PADDR == bmr_pkg::OFF_CFGB_LO)
         cfg_reg <= unpack_b(cfg_reg, cfgb_next);
   end

   // Rate set follows the option bit and the command's mode bits
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
         rate_reg <= bmr_pkg::RATE_422HZ;
      else
         rate_reg <= bmr_pkg::bmr_rate_t'({cfg_reg.converter_rate_option,
                                            CONV_MODE});
   end

   // ************************************************************
   // Result slots
   // ************************************************************
   // Bus writes never reach here, so result groups stay read-only
   always_comb
   begin
      res_we = '0;
      res_wd = '0;
      // Channel number equals slot: cells, GPIO 1-5, reference, GPIO 6-8
      if (RESULT.valid && RESULT.chan < 5'(N))
      begin
         res_we[RESULT.chan] = 1'b1;
         res_wd[RESULT.chan] = RESULT.data;
      end
      // Overlap placement wins over a plain result in the same cycle
      if (OVERLAP.valid)
      begin
         res_we[bmr_pkg::SLOT_C6_ADC2]  = 1'b1;
         res_wd[bmr_pkg::SLOT_C6_ADC2]  = OVERLAP.c6_adc2;
         res_we[bmr_pkg::SLOT_C6_ADC1]  = 1'b1;
         res_wd[bmr_pkg::SLOT_C6_ADC1]  = OVERLAP.c6_adc1;
         res_we[bmr_pkg::SLOT_C11_ADC3] = 1'b1;
         res_wd[bmr_pkg::SLOT_C11_ADC3] = OVERLAP.c11_adc3;
         res_we[bmr_pkg::SLOT_C11_ADC2] = 1'b1;
         res_wd[bmr_pkg::SLOT_C11_ADC2] = OVERLAP.c11_adc2;
      end
   end

   bmr_result_store
   #(
      .N (N),
      .W (16)
   )
   u_store
   (
      .clk  (CORE_CLK),
      .rstn (RSTN),
      .we   (res_we),
      .wd   (res_wd),
      .q    (res_q)
   );

   // ************************************************************
   // Outputs
   // ************************************************************
   assign PRDATA  = prdata_reg;
   assign PREADY  = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign CFG     = cfg_reg;
   assign RATE    = rate_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   logic [31:0] cell_a_lo;
   logic [2:0]  rate_src;
   assign cell_a_lo = {res_q[1], res_q[0]};
   assign rate_src  = {cfg_reg.converter_rate_option, CONV_MODE};

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);

   property p_ready_one_wait;
      PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY;
   endproperty
   a_ready_one_wait: assert property (p_ready_one_wait)
      else $error("Ready not given after one wait state");

   property p_a0_fields;
      wr_go && PADDR == bmr_pkg::OFF_CFGA_LO && PSTRB[0] |=>
         CFG.reference_keep_on == $past(PWDATA[2]) &&
         CFG.discharge_timer_enable == $past(PWDATA[1]) &&
         CFG.converter_rate_option == $past(PWDATA[0]) &&
         CFG.gpio_pulldown[4:0] == $past(PWDATA[7:3]);
   endproperty
   a_a0_fields: assert property (p_a0_fields)
      else $error("Config A byte 0 fields wrong");

   property p_uv_thresh;
      wr_go && PADDR == bmr_pkg::OFF_CFGA_LO && PSTRB[1] && PSTRB[2] |=>
         CFG.undervoltage_threshold == $past(PWDATA[19:8]);
   endproperty
   a_uv_thresh: assert property (p_uv_thresh)
      else $error("Undervoltage threshold wrong");

   property p_ov_thresh;
      wr_go && PADDR == bmr_pkg::OFF_CFGA_LO && PSTRB[2] && PSTRB[3] |=>
         CFG.overvoltage_threshold == $past(PWDATA[31:20]);
   endproperty
   a_ov_thresh: assert property (p_ov_thresh)
      else $error("Overvoltage threshold wrong");

   property p_dcc_low;
      wr_go && PADDR == bmr_pkg::OFF_CFGA_HI && PSTRB[1:0] == 2'b11 |=>
         CFG.cell_discharge_enable[11:0] == $past(PWDATA[11:0]) &&
         CFG.discharge_timeout == $past(PWDATA[15:12]);
   endproperty
   a_dcc_low: assert property (p_dcc_low)
      else $error("Discharge enables or timeout wrong");

   property p_b0_fields;
      wr_go && PADDR == bmr_pkg::OFF_CFGB_LO && PSTRB[0] |=>
         CFG.cell_discharge_enable[14:12] == $past(PWDATA[6:4]) &&
         CFG.gpio_pulldown[8:5] == $past(PWDATA[3:0]);
   endproperty
   a_b0_fields: assert property (p_b0_fields)
      else $error("Config B byte 0 fields wrong");

   property p_b1_fields;
      wr_go && PADDR == bmr_pkg::OFF_CFGB_LO && PSTRB[1] |=>
         CFG.forced_redundancy_failure == $past(PWDATA[14]) &&
         CFG.redundancy_path_select == $past(PWDATA[13:12]) &&
         CFG.discharge_mute == $past(PWDATA[15]);
   endproperty
   a_b1_fields: assert property (p_b1_fields)
      else $error("Config B byte 1 fields wrong");

   property p_b_reserved;
      PREADY && !PWRITE && (PADDR == bmr_pkg::OFF_CFGB_LO ||
                            PADDR == bmr_pkg::OFF_CFGB_HI) |->
         PRDATA[31:16] == 16'h0000 && !PRDATA[7] && PRDATA[9:8] == 2'b00;
   endproperty
   a_b_reserved: assert property (p_b_reserved)
      else $error("Reserved config B bits not zero");

   property p_cell_a_read;
      PREADY && !PWRITE && PADDR == bmr_pkg::OFF_RES_BASE |->
         PRDATA == $past(cell_a_lo);
   endproperty
   a_cell_a_read: assert property (p_cell_a_read)
      else $error("Cell group A low word wrong");

   property p_overlap_c6;
      OVERLAP.valid |=> res_q[bmr_pkg::SLOT_C6_ADC2] == $past(OVERLAP.c6_adc2)
         && res_q[bmr_pkg::SLOT_C6_ADC1] == $past(OVERLAP.c6_adc1);
   endproperty
   a_overlap_c6: assert property (p_overlap_c6)
      else $error("Overlap cell 6 placement wrong");

   property p_overlap_c11;
      OVERLAP.valid |=>
         res_q[bmr_pkg::SLOT_C11_ADC3] == $past(OVERLAP.c11_adc3) &&
         res_q[bmr_pkg::SLOT_C11_ADC2] == $past(OVERLAP.c11_adc2);
   endproperty
   a_overlap_c11: assert property (p_overlap_c11)
      else $error("Overlap cell 11 placement wrong");

   property p_ro_results;
      wr_go && is_res && !RESULT.valid && !OVERLAP.valid |=> $stable(res_q);
   endproperty
   a_ro_results: assert property (p_ro_results)
      else $error("Bus write changed a result");

   property p_rate_set;
      1'b1 |=> RATE == $past(rate_src);
   endproperty
   a_rate_set: assert property (p_rate_set)
      else $error("Rate set does not follow option bit");

   c_cfg_write:  cover property (wr_go && PADDR == bmr_pkg::OFF_CFGA_LO);
   c_overlap:    cover property (OVERLAP.valid ##[1:20] PREADY && is_res);
   c_unmapped:   cover property (PREADY && PSLVERR);
   c_res_read:   cover property (PREADY && !PWRITE && is_res && PADDR[2]);

endmodule : bmr_regs

//--- bmr_regs_tb.sv
module bmr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  CORE_CLK = 1'b0;
   logic                  RSTN = 1'b0;
   logic                  PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [7:0]            PADDR;
   logic [31:0]           PWDATA, PRDATA, rd;
   logic [3:0]            PSTRB;
   logic                  err;
   logic [1:0]            CONV_MODE = 2'h0;
   bmr_pkg::bmr_result_t  RESULT = '0;
   bmr_pkg::bmr_overlap_t OVERLAP = '0;
   bmr_pkg::bmr_cfg_t     CFG;
   bmr_pkg::bmr_rate_t    RATE;
   int                    n_mismatch = 0;
   int                    checked = 0;

   // 50 MHz
   always #10 CORE_CLK = ~CORE_CLK;

   bmr_regs dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .RESULT(RESULT), .OVERLAP(OVERLAP), .CONV_MODE(CONV_MODE),
      .CFG(CFG), .RATE(RATE));
   bmr_host host (.CORE_CLK(CORE_CLK), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Read one word and compare data together with the error flag
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic eexp);
      host.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
      chk({err, rd}, {eexp, exp});
   endtask : rd_chk

   // Distinct bytes per slot so swapped halves cannot pass
   function automatic logic [15:0] rv(input int k);
      return {8'(k) + 8'h80, 8'(k)};
   endfunction : rv

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      chk(CFG, '0);
      chk(RATE, bmr_pkg::RATE_422HZ);
      rd_chk(8'h00, 32'h0, 1'b0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_cfg;
      host.grp_wr(8'h00, 32'hAB9C34F5, 32'h00006E81);
      host.xfer(1'b1, 8'h08, 32'hFFFFFFFF, 4'hF, rd, err);
      host.xfer(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF, rd, err);
      @(posedge CORE_CLK);
      chk(CFG.gpio_pulldown, 9'h1FE);
      chk({CFG.reference_keep_on, CFG.discharge_timer_enable,
           CFG.converter_rate_option}, 3'b101);
      chk(CFG.undervoltage_threshold, 12'hC34);
      chk(CFG.overvoltage_threshold, 12'hAB9);
      chk({CFG.cell_discharge_enable, CFG.discharge_timeout},
          19'h7E816);
      chk({CFG.discharge_mute, CFG.forced_redundancy_failure}, 2'h3);
      chk({CFG.redundancy_path_select, CFG.timer_monitor_enable,
           CFG.extra_discharge_control}, 4'hF);
      rd_chk(8'h00, 32'hAB9C34F5, 1'b0);
      rd_chk(8'h08, 32'h0000FC7F, 1'b0);
      rd_chk(8'h0C, 32'h0, 1'b0);
      host.xfer(1'b1, 8'h04, 32'hFFFF0000, 4'h1, rd, err);
      rd_chk(8'h04, 32'h00006E00, 1'b0);
      $display("t_cfg done");
   endtask : t_cfg

   task automatic t_rate;
      // Expected set, indexed by option bit then mode
      bmr_pkg::bmr_rate_t exp_rate [8] = '{bmr_pkg::RATE_422HZ,
         bmr_pkg::RATE_27KHZ, bmr_pkg::RATE_7KHZ, bmr_pkg::RATE_26HZ,
         bmr_pkg::RATE_1KHZ, bmr_pkg::RATE_14KHZ, bmr_pkg::RATE_3KHZ,
         bmr_pkg::RATE_2KHZ};
      for (int o = 0; o < 2; o++)
      begin
         host.xfer(1'b1, 8'h00, 32'(o), 4'h1, rd, err);
         for (int m = 0; m < 4; m++)
         begin
            CONV_MODE <= 2'(m);
            repeat (2) @(posedge CORE_CLK);
            chk(RATE, exp_rate[4 * o + m]);
         end
      end
      $display("t_rate done");
   endtask : t_rate

   task automatic t_result;
      // Back-to-back strobes, out-of-range channels included
      for (int k = 0; k < 32; k++)
      begin
         @(posedge CORE_CLK);
         RESULT <= '{1'b1, 5'(k), (k < 24) ? rv(k) : 16'hFFFF};
      end
      @(posedge CORE_CLK);
      RESULT.valid <= 1'b0;
      for (int g = 0; g < 8; g++)
      begin
         rd_chk(8'(8'h10 + 8 * g), {rv(3 * g + 1), rv(3 * g)},
                1'b0);
         rd_chk(8'(8'h14 + 8 * g), {16'h0, rv(3 * g + 2)},
                1'b0);
      end
      host.xfer(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF, rd, err);
      rd_chk(8'h10, {rv(1), rv(0)}, 1'b0);
      rd_chk(8'h50, 32'h0, 1'b1);
      rd_chk(8'h12, 32'h0, 1'b1);
      $display("t_result done");
   endtask : t_result

   task automatic t_overlap;
      // Same-cycle plain result to cell 7 must lose to the overlap
      @(posedge CORE_CLK);
      OVERLAP <= '{1'b1, 16'h6A02, 16'h6A01, 16'hB303, 16'hB302};
      RESULT  <= '{1'b1, 5'd6, 16'h1234};
      @(posedge CORE_CLK);
      OVERLAP.valid <= 1'b0;
      RESULT.valid  <= 1'b0;
      rd_chk(8'h20, 32'h6A016A02, 1'b0);
      rd_chk(8'h24, {16'h0, rv(8)}, 1'b0);
      rd_chk(8'h30, 32'hB302B303, 1'b0);
      $display("t_overlap done");
   endtask : t_overlap

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial
   begin
      repeat (10) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      @(posedge CORE_CLK);
      t_reset();
      t_cfg();
      t_rate();
      t_result();
      t_overlap();
      test_done();
   end

   // Whole run is about 4 us; the 300 us limit means a hang
   initial
   begin
      #300us;
      n_mismatch++;
      test_done();
   end
endmodule : bmr_regs_tb

//--- bmr_result_store.sv
module bmr_result_store
#(
   parameter int N = 24,
   parameter int W = 16
)
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // Per-slot write
   input  wire logic [N-1:0]        we,
   input  wire logic [N-1:0][W-1:0] wd,
   // All slots
   output logic      [N-1:0][W-1:0] q
);

   logic [W-1:0] mem [N];

   // ************************************************************
   // Storage, each slot written on its own enable
   // ************************************************************
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < N; i++)
      begin
         if (!rstn)
            mem[i] <= bmr_pkg::RES_RST;
         else if (we[i])
            mem[i] <= wd[i];
      end
   end

   // Flat view for the read mux
   always_comb
   begin
      for (int i = 0; i < N; i++)
         q[i] = mem[i];
   end

endmodule : bmr_result_store
